// file: bench/dual_timer_checker.sv
// bus timing and flag checks on the dual timer ports
`timescale 1ns/1ps
module dual_timer_checker
(
    // clock and control
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        CE,
    // bus
    input wire logic        HSEL,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic [31:0] HRDATA,
    // flags
    input wire logic        VEC0_ACK,
    input wire logic        VEC1_ACK,
    input wire logic        TF0_FLAG,
    input wire logic        TF1_FLAG
);
    logic take;
    logic wr_ph_q;
    assign take = HSEL && HREADY && HTRANS[1] && CE;
    always_ff @(posedge CLK or posedge RST)
        if (RST)
            wr_ph_q <= 1'b0;
        else if (CE)
            wr_ph_q <= take && HWRITE;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    resp_okay_a: assert property (!HRESP) else $error("bus response not okay");
    rd_wait_a: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");
    wr_nowait_a: assert property (take && HWRITE |=> HREADYOUT) else $error("write stalled");
    wait_one_a: assert property (!HREADYOUT && CE |=> HREADYOUT) else $error("wait too long");
    rdata_hold_a: assert property (!$rose(HREADYOUT) |-> $stable(HRDATA))
        else $error("read data moved");
    tf0_clear_a: assert property ($fell(TF0_FLAG) |-> $past(VEC0_ACK) || $past(wr_ph_q))
        else $error("timer 0 flag dropped without cause");
    tf1_clear_a: assert property ($fell(TF1_FLAG) |-> $past(VEC1_ACK) || $past(wr_ph_q))
        else $error("timer 1 flag dropped without cause");
    ce_freeze_a: assert property (!CE |=> $stable({TF0_FLAG, TF1_FLAG, HREADYOUT, HRDATA}))
        else $error("state moved with clock enable low");
endmodule : dual_timer_checker
bind dual_timer dual_timer_checker i_chk (.CLK, .RST, .CE, .HSEL, .HTRANS, .HWRITE, .HREADY,
    .HREADYOUT, .HRESP, .HRDATA, .VEC0_ACK, .VEC1_ACK, .TF0_FLAG, .TF1_FLAG);

// file: bench/pin_source.sv
// model of the external gate and event pins of both timers
`timescale 1ns/1ps
module pin_source
(
    // requests from the bench
    input  wire logic           clk,
    input  wire logic [1:0]     gate_req,
    input  wire logic [1:0]     ev_req,
    // pins seen by the timers
    output tmr_pkg::pins_s      pins0,
    output tmr_pkg::pins_s      pins1
);
    import tmr_pkg::*;
    initial
    begin
        pins0 = '0;
        pins1 = '0;
    end
    // pins move just after the edge; events hold each level a full cycle
    always @(posedge clk)
    begin
        pins0.gate_pin  <= gate_req[0];
        pins1.gate_pin  <= gate_req[1];
        pins0.event_pin <= ev_req[0] & ~pins0.event_pin;
        pins1.event_pin <= ev_req[1] & ~pins1.event_pin;
    end
endmodule : pin_source

// file: bench/tb_top.sv
// self-checking bench of the dual timer
`timescale 1ns/1ps
module tb_top;
    import tmr_pkg::*;
    typedef struct packed {
        logic [7:0] mode, run, lo, hi, n, k, elo, ehi, ectl;
        logic       t1;
    } row_s;
    logic        CLK = 1'b0, RST = 1'b1, CE = 1'b1, HWRITE = 1'b0;
    logic        VEC0_ACK = 1'b0, VEC1_ACK = 1'b0, HREADYOUT, HRESP, TF0_FLAG, TF1_FLAG, IRQ;
    logic [9:0]  HADDR = '0;
    logic [1:0]  HTRANS = '0, gate_req = '0, ev_req = '0, sel;
    logic [31:0] HWDATA = '0, HRDATA;
    pins_s       pins0, pins1;
    int          n_mismatch = 0, checked = 0, cyc = 0;
    row_s        r;
    row_s        rows [9] = '{
        '{8'h08, 8'h10, 8'hfe, 8'hff, 8'd2, 8'd0, 8'he0, 8'h00, 8'h30, 1'b0},
        '{8'h09, 8'h10, 8'hfe, 8'h12, 8'd3, 8'd0, 8'h01, 8'h13, 8'h10, 1'b0},
        '{8'h0a, 8'h10, 8'hfe, 8'h40, 8'd3, 8'd0, 8'h41, 8'h40, 8'h30, 1'b0},
        '{8'h05, 8'h10, 8'hfd, 8'hff, 8'd0, 8'd3, 8'h00, 8'h00, 8'h30, 1'b0},
        '{8'h80, 8'h40, 8'h00, 8'h05, 8'd5, 8'd0, 8'h05, 8'h05, 8'h40, 1'b1},
        '{8'h90, 8'h40, 8'hff, 8'hff, 8'd1, 8'd0, 8'h00, 8'h00, 8'hc0, 1'b1},
        '{8'ha0, 8'h40, 8'hff, 8'h80, 8'd2, 8'd0, 8'h81, 8'h80, 8'hc0, 1'b1},
        '{8'hb0, 8'h40, 8'h10, 8'h20, 8'd4, 8'd0, 8'h10, 8'h20, 8'h40, 1'b1},
        '{8'h50, 8'h40, 8'h00, 8'h00, 8'd0, 8'd4, 8'h04, 8'h00, 8'h40, 1'b1}};
    always #20 CLK = ~CLK;
    dual_timer i_dut (.CLK, .RST, .CE, .HSEL(1'b1), .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2),
        .HWDATA, .HREADY(HREADYOUT), .HREADYOUT, .HRESP, .HRDATA, .TIMER0_PINS(pins0),
        .TIMER1_PINS(pins1), .VEC0_ACK, .VEC1_ACK, .TF0_FLAG, .TF1_FLAG, .IRQ);
    pin_source i_pins (.clk(CLK), .gate_req, .ev_req, .pins0, .pins1);
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // one single transfer; entered just after a rising edge
    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] wd,
                       output logic [31:0] rd);
        HADDR <= {idx, 2'b00};
        HTRANS <= 2'h2;
        HWRITE <= w;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= {24'h0, wd};
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        bus(idx, 1'b1, wd, d);
    endtask : wr
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        bus(idx, 1'b0, 8'h00, d);
        cmp(d, {24'h0, exp});
    endtask : rdc
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            finish_test();
        end
    end
    initial
    begin
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        rdc(IDX_CTRL, 8'h00);
        rdc(IDX_MODE, MODE_RST);
        wr(8'h95, 8'hff);
        rdc(8'h95, 8'h00);
        wr(IDX_IRQ_MASK, 8'h03);
        foreach (rows[i])
        begin
            r = rows[i];
            sel = r.t1 ? 2'b10 : 2'b01;
            wr(IDX_CTRL, 8'h00);
            wr(IDX_IRQ_STATUS, 8'h03);
            wr(IDX_MODE, r.mode);
            wr(r.t1 ? IDX_T1_LO : IDX_T0_LO, r.lo);
            wr(r.t1 ? IDX_T1_HI : IDX_T0_HI, r.hi);
            wr(IDX_CTRL, r.run);
            gate_req <= (r.n != 0) ? sel : 2'b00;
            ev_req <= (r.k != 0) ? sel : 2'b00;
            repeat (r.n + 2 * r.k) @(posedge CLK);
            gate_req <= 2'b00;
            ev_req <= 2'b00;
            repeat (3) @(posedge CLK);
            rdc(r.t1 ? IDX_T1_LO : IDX_T0_LO, r.elo);
            rdc(r.t1 ? IDX_T1_HI : IDX_T0_HI, r.ehi);
            rdc(IDX_CTRL, r.ectl);
            cmp({31'h0, IRQ}, {31'h0, r.ectl[7] | r.ectl[5]});
            {VEC1_ACK, VEC0_ACK} <= sel;
            @(posedge CLK);
            {VEC1_ACK, VEC0_ACK} <= 2'b00;
            @(posedge CLK);
            cmp({30'h0, TF1_FLAG, TF0_FLAG}, 32'h0);
        end
        wr(IDX_IRQ_MASK, 8'h01);
        wr(IDX_CTRL, 8'h00);
        wr(IDX_IRQ_STATUS, 8'h03);
        wr(IDX_MODE, 8'h03);
        wr(IDX_T0_LO, 8'h33);
        wr(IDX_T0_HI, 8'hfe);
        wr(IDX_CTRL, 8'h40);
        wr(IDX_CTRL, 8'h00);
        rdc(IDX_T0_HI, 8'h00);
        rdc(IDX_T0_LO, 8'h33);
        rdc(IDX_CTRL, 8'h80);
        cmp({31'h0, IRQ}, 32'h0);
        rdc(IDX_IRQ_STATUS, 8'h02);
        wr(IDX_IRQ_STATUS, 8'h02);
        rdc(IDX_IRQ_STATUS, 8'h00);
        wr(IDX_CTRL, 8'h10);
        CE <= 1'b0;
        repeat (3) @(posedge CLK);
        CE <= 1'b1;
        wr(IDX_CTRL, 8'h00);
        rdc(IDX_T0_LO, 8'h35);
        wr(IDX_MODE, 8'h5a);
        rdc(IDX_MODE, 8'h5a);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        cmp({29'h0, TF1_FLAG, TF0_FLAG, IRQ}, 32'h0);
        rdc(IDX_MODE, MODE_RST);
        finish_test();
    end
endmodule : tb_top

// file: core/dual_timer.sv
// dual 16-bit timer/counter with mode control, overflow flags and AHB-Lite registers
//
// Overview of operation
// - timer 1 gate needs pin high and run
// - timer 1 source: core clock or pin events
// - timer 1 mode 0: 5-bit prescaler feeds high
// - timer 1 mode 1: 16-bit cascade, no prescaler
// - timer 1 mode 2: low reloads from high
// - timer 1 mode 3: count held
// - timer 0 gate needs pin high and run
// - timer 0 source: core clock or pin events
// - timer 0 mode 0: 5-bit prescaler feeds high
// - timer 0 mode 1: 16-bit cascade, no prescaler
// - timer 0 mode 2: low reloads from high
// - timer 0 mode 3: split, high uses timer 1 run
// - timer 1 flag set on overflow, on timer 0 high overflow instead in timer 0 mode 3; cleared at vector
// - timer 1 run bit starts and stops it
// - timer 0 flag set on overflow, cleared at vector
// - timer 0 run bit starts and stops it
// - timer mode advances every core clock
// - counter advances on sampled high-to-low edge
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps

module dual_timer
#(
    parameter int ADDR_W = 10
)
(
    // clock, reset, enable
    input  wire logic                        CLK,
    input  wire logic                        RST,
    input  wire logic                        CE,
    // ahb-lite slave
    input  wire logic                        HSEL,
    input  wire logic [ADDR_W-1:0]           HADDR,
    input  wire logic [1:0]                  HTRANS,
    input  wire logic                        HWRITE,
    input  wire logic [2:0]                  HSIZE,
    input  wire logic [31:0]                 HWDATA,
    input  wire logic                        HREADY,
    output logic                             HREADYOUT,
    output logic                             HRESP,
    output logic [31:0]                      HRDATA,
    // timer pins
    input  wire tmr_pkg::pins_s              TIMER0_PINS,
    input  wire tmr_pkg::pins_s              TIMER1_PINS,
    // core vector acknowledge, one pulse per taken interrupt
    input  wire logic                        VEC0_ACK,
    input  wire logic                        VEC1_ACK,
    // flags and interrupt
    output logic                             TF0_FLAG,
    output logic                             TF1_FLAG,
    output logic                             IRQ
);
    import tmr_pkg::*;

    if (ADDR_W < ADDR_W_MIN)
    begin : g_addr_check
        $error("ADDR_W too small for the register map");
    end

    if (ADDR_W > 32)
    begin : g_addr_max
        $error("ADDR_W wider than the bus address");
    end

    if (PRESCALE_W >= 8)
    begin : g_prescale_check
        $error("prescaler must be narrower than the low byte");
    end

    if (IRQ_T0_BIT == IRQ_T1_BIT)
    begin : g_irq_bits_check
        $error("the two interrupt status bits must differ");
    end

    state_s s_q;
    state_s s_d;

    // one count step of a timer in the non-split modes
    function automatic step_s count_step(input mode_e m, input count_s c, input logic inc);
        step_s r;
        r.cnt = c;
        r.ovf = 1'b0;
        if (inc)
        begin
            unique case (m)
                MODE_PRESCALED:
                begin
                    r.cnt.lo[PRESCALE_W-1:0] = c.lo[PRESCALE_W-1:0] + 5'h01;
                    if (&c.lo[PRESCALE_W-1:0])
                    begin
                        r.cnt.hi = c.hi + 8'h01;
                        r.ovf    = &c.hi;
                    end
                end
                MODE_CASCADED:
                begin
                    r.cnt = count_s'({c.hi, c.lo} + 16'h0001);
                    r.ovf = &{c.hi, c.lo};
                end
                MODE_RELOAD:
                begin
                    r.cnt.lo = (&c.lo) ? c.hi : c.lo + 8'h01;
                    r.ovf    = &c.lo;
                end
                MODE_SPLIT:
                begin
                    r.cnt = c;
                end
            endcase
        end
        return r;
    endfunction : count_step

    // run bit, qualified by the gate pin only when gating is selected
    function automatic logic run_enable(input logic run, input logic gate, input logic pin);
        return run & (~gate | pin);
    endfunction : run_enable

    // a high sample followed by a low sample is one counted event
    function automatic logic fall_seen(input logic prev, input logic now);
        return prev & ~now;
    endfunction : fall_seen

    // timers step every enabled cycle, counters only on a seen fall
    function automatic logic count_inc(input logic en, input logic counter, input logic fall);
        return en & (counter ? fall : 1'b1);
    endfunction : count_inc

    // eight-bit up count; the top bit is the carry out of the byte
    function automatic logic [8:0] byte_step(input logic [7:0] b, input logic inc);
        return {1'b0, b} + {8'h00, inc};
    endfunction : byte_step

    // two-bit mode field of one timer
    function automatic mode_e mode_field(input logic [7:0] mode, input int lsb);
        return mode_e'(mode[lsb +: 2]);
    endfunction : mode_field

    // an address phase is taken when selected, ready and NONSEQ or SEQ
    function automatic logic bus_take(input logic sel, input logic rdy, input logic [1:0] tr);
        return sel & rdy & tr[1];
    endfunction : bus_take

    // level interrupt: any status bit that is also unmasked
    function automatic logic irq_level(input logic [1:0] stat, input logic [1:0] mask);
        return |(stat & mask);
    endfunction : irq_level

    // register read view; unmapped indices read as zero
    function automatic logic [31:0] read_word(input state_s s);
        logic [31:0] w;
        w = 32'h00000000;
        unique case (s.idx)
            IDX_CTRL:
            begin
                w = {24'h000000, s.tf1, s.tr1, s.tf0, s.tr0, 4'h0};
            end
            IDX_MODE:
            begin
                w = {24'h000000, s.mode};
            end
            IDX_T0_LO:
            begin
                w = {24'h000000, s.t0.lo};
            end
            IDX_T1_LO:
            begin
                w = {24'h000000, s.t1.lo};
            end
            IDX_T0_HI:
            begin
                w = {24'h000000, s.t0.hi};
            end
            IDX_T1_HI:
            begin
                w = {24'h000000, s.t1.hi};
            end
            IDX_IRQ_STATUS:
            begin
                w = {30'h00000000, s.irq_stat};
            end
            IDX_IRQ_MASK:
            begin
                w = {30'h00000000, s.irq_mask};
            end
            default:
            begin
                w = 32'h00000000;
            end
        endcase
        return w;
    endfunction : read_word

    mode_e       m0;
    mode_e       m1;
    logic        timer0_pin_gating;
    logic        timer1_pin_gating;
    logic        csel0;
    logic        csel1;
    logic        edge0;
    logic        edge1;
    logic        en0;
    logic        en1;
    logic        inc0;
    logic        inc1;
    step_s       st0;
    step_s       st1;
    logic        ovf0;
    logic        ovf1;
    logic        aphase;
    logic        wr_hit;
    logic [31:0] rd_word;

    always_comb
    begin
        s_d = s_q;
        m0  = mode_field(s_q.mode, MODE_T0_LSB);
        m1  = mode_field(s_q.mode, MODE_T1_LSB);

        // mode register fields of each timer
        timer0_pin_gating = s_q.mode[MODE_TIMER0_PIN_GATING_BIT];
        timer1_pin_gating = s_q.mode[MODE_TIMER1_PIN_GATING_BIT];
        csel0 = s_q.mode[MODE_CT0_BIT];
        csel1 = s_q.mode[MODE_CT1_BIT];

        // pin sampling; a fall between two samples is one event
        s_d.ev0 = TIMER0_PINS.event_pin;
        s_d.ev1 = TIMER1_PINS.event_pin;
        edge0   = fall_seen(s_q.ev0, TIMER0_PINS.event_pin);
        edge1   = fall_seen(s_q.ev1, TIMER1_PINS.event_pin);

        en0  = run_enable(s_q.tr0, timer0_pin_gating, TIMER0_PINS.gate_pin);
        en1  = run_enable(s_q.tr1, timer1_pin_gating, TIMER1_PINS.gate_pin);
        inc0 = count_inc(en0, csel0, edge0);
        inc1 = count_inc(en1, csel1, edge1);

        st0 = count_step(m0, s_q.t0, inc0);
        st1 = count_step(m1, s_q.t1, inc1);
        if (m0 == MODE_SPLIT)
        begin
            // low byte on timer 0 controls, high byte as a plain timer on timer 1 run
            {ovf0, st0.cnt.lo} = byte_step(s_q.t0.lo, inc0);
            {ovf1, st0.cnt.hi} = byte_step(s_q.t0.hi, s_q.tr1);
        end
        else
        begin
            ovf0 = st0.ovf;
            ovf1 = st1.ovf;
        end
        s_d.t0 = st0.cnt;
        s_d.t1 = st1.cnt;

        // bus address phase
        aphase = bus_take(HSEL, HREADY, HTRANS);
        s_d.wr_pend = 1'b0;
        if (aphase)
        begin
            s_d.idx     = HADDR[9:2];
            s_d.wr_pend = HWRITE;
            if (!HWRITE)
            begin
                s_d.rd_pend = 1'b1;
                s_d.hready  = 1'b0;
            end
        end

        // write data phase; software data overrides the count of this cycle
        wr_hit = s_q.wr_pend;
        if (wr_hit)
        begin
            unique case (s_q.idx)
                IDX_CTRL:
                begin
                    s_d.tr1 = HWDATA[CTRL_TR1_BIT];
                    s_d.tr0 = HWDATA[CTRL_TR0_BIT];
                    s_d.tf1 = HWDATA[CTRL_TF1_BIT];
                    s_d.tf0 = HWDATA[CTRL_TF0_BIT];
                end
                IDX_MODE:
                begin
                    s_d.mode = HWDATA[7:0];
                end
                IDX_T0_LO:
                begin
                    s_d.t0.lo = HWDATA[7:0];
                end
                IDX_T1_LO:
                begin
                    s_d.t1.lo = HWDATA[7:0];
                end
                IDX_T0_HI:
                begin
                    s_d.t0.hi = HWDATA[7:0];
                end
                IDX_T1_HI:
                begin
                    s_d.t1.hi = HWDATA[7:0];
                end
                IDX_IRQ_STATUS:
                begin
                    s_d.irq_stat = s_q.irq_stat & ~HWDATA[1:0];
                end
                IDX_IRQ_MASK:
                begin
                    s_d.irq_mask = HWDATA[1:0];
                end
                default:
                begin
                    s_d.idx = s_d.idx;
                end
            endcase
        end

        // flags: vector clears, an overflow in the same cycle wins
        if (VEC0_ACK)
        begin
            s_d.tf0 = 1'b0;
        end
        if (VEC1_ACK)
        begin
            s_d.tf1 = 1'b0;
        end
        if (ovf0)
        begin
            s_d.tf0 = 1'b1;
        end
        if (ovf1)
        begin
            s_d.tf1 = 1'b1;
        end
        s_d.irq_stat[IRQ_T0_BIT] = s_d.irq_stat[IRQ_T0_BIT] | ovf0;
        s_d.irq_stat[IRQ_T1_BIT] = s_d.irq_stat[IRQ_T1_BIT] | ovf1;
        s_d.irq = irq_level(s_d.irq_stat, s_d.irq_mask);

        // read data phase, one wait state so a preceding write is seen
        rd_word = read_word(s_q);
        if (s_q.rd_pend)
        begin
            s_d.hrdata  = rd_word;
            s_d.hready  = 1'b1;
            s_d.rd_pend = 1'b0;
        end
        s_d.hresp = 1'b0;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            s_q          <= '0;
            s_q.mode     <= MODE_RST;
            s_q.t0       <= {COUNT_RST, COUNT_RST};
            s_q.t1       <= {COUNT_RST, COUNT_RST};
            s_q.irq_stat <= IRQ_RST;
            s_q.irq_mask <= IRQ_RST;
            s_q.hready   <= 1'b1;
        end
        else if (CE)
        begin
            s_q <= s_d;
        end
    end

    assign HREADYOUT = s_q.hready;
    assign HRESP     = s_q.hresp;
    assign HRDATA    = s_q.hrdata;
    assign TF0_FLAG  = s_q.tf0;
    assign TF1_FLAG  = s_q.tf1;
    assign IRQ       = s_q.irq;

endmodule : dual_timer

// file: core/tmr_pkg.sv
// shared constants, types and register map of the dual timer/counter
package tmr_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL       = 8'h88;
    localparam logic [7:0] IDX_MODE       = 8'h89;
    localparam logic [7:0] IDX_T0_LO      = 8'h8a;
    localparam logic [7:0] IDX_T1_LO      = 8'h8b;
    localparam logic [7:0] IDX_T0_HI      = 8'h8c;
    localparam logic [7:0] IDX_T1_HI      = 8'h8d;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h90;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'h91;

    // mode register fields
    localparam int MODE_TIMER1_PIN_GATING_BIT = 7;
    localparam int MODE_CT1_BIT   = 6;
    localparam int MODE_T1_LSB    = 4;
    localparam int MODE_TIMER0_PIN_GATING_BIT = 3;
    localparam int MODE_CT0_BIT   = 2;
    localparam int MODE_T0_LSB    = 0;

    // control register fields
    localparam int CTRL_TF1_BIT = 7;
    localparam int CTRL_TR1_BIT = 6;
    localparam int CTRL_TF0_BIT = 5;
    localparam int CTRL_TR0_BIT = 4;

    // interrupt status and mask fields
    localparam int IRQ_T0_BIT = 0;
    localparam int IRQ_T1_BIT = 1;

    // reset values
    localparam logic [7:0] MODE_RST  = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [1:0] IRQ_RST   = 2'h0;

    // bus geometry and prescaler width
    localparam int ADDR_W_MIN = 10;
    localparam int PRESCALE_W = 5;

    typedef enum logic [1:0] {
        MODE_PRESCALED = 2'b00,
        MODE_CASCADED  = 2'b01,
        MODE_RELOAD    = 2'b10,
        MODE_SPLIT     = 2'b11
    } mode_e;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } count_s;

    typedef struct packed {
        count_s cnt;
        logic   ovf;
    } step_s;

    typedef struct packed {
        logic gate_pin;
        logic event_pin;
    } pins_s;

    typedef struct packed {
        logic [7:0]  mode;
        logic        tf1;
        logic        tr1;
        logic        tf0;
        logic        tr0;
        count_s      t0;
        count_s      t1;
        logic        ev0;
        logic        ev1;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic        irq;
        logic        rd_pend;
        logic        wr_pend;
        logic [7:0]  idx;
        logic        hready;
        logic        hresp;
        logic [31:0] hrdata;
    } state_s;

endpackage : tmr_pkg
